// *** inc/pfr_pkg.sv ***
// constants and types shared by the power-fail restart control
`default_nettype none
package pfr_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RUN_WAIT_S = 2;
  localparam int RUN_WAIT_CYC = RUN_WAIT_S * CLK_HZ;
  localparam int TC_STEP_S = 6;
  localparam int TC_STEP_CYC = TC_STEP_S * CLK_HZ;
  localparam logic [15:0] TC_MIN = 16'h0005;
  localparam logic [15:0] TC_MAX = 16'h02EE;
  localparam logic [9:0] TC_DEF_SMALL = 10'h032;
  localparam logic [9:0] TC_DEF_LARGE = 10'h064;
  localparam logic [15:0] LEVEL_RST = 16'h0064;
  localparam logic [15:0] START_FREQ_RST = 16'h0005;
  localparam logic [2:0] MODE_TRIP = 3'h0;
  localparam logic [2:0] MODE_TRIP_LATE = 3'h1;
  localparam logic [2:0] MODE_RIDE = 3'h3;
  localparam logic [2:0] MODE_SAVED = 3'h4;
  localparam logic [2:0] MODE_START = 3'h5;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TC = 4'h1;
  localparam logic [3:0] REG_LEVEL = 4'h2;
  localparam logic [3:0] REG_START = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h5;
  localparam logic [3:0] REG_SAVED = 4'h6;
  localparam logic [3:0] REG_STATE = 4'h7;
  localparam int CTRL_CLR_BIT = 4;
  localparam int EV_UV = 0;
  localparam int EV_PF = 1;
  localparam int EV_RESTART = 2;
  localparam int EV_CANCEL = 3;
  localparam int EV_OVL = 4;
  localparam int SYN_UV = 0;
  localparam int SYN_CONT = 1;
  localparam int SYN_PWR = 2;
  localparam int SYN_RUN = 3;
  localparam int SYN_STRAP = 4;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_CONT = 5'h02,
    ST_COAST = 5'h04,
    ST_WAIT = 5'h08,
    ST_TRIP = 5'h10
  } pf_state_t;
endpackage
`default_nettype wire

// *** inc/ovl_if.sv ***
// link between restart control and the thermal overload model
`timescale 1ns/10ps
`default_nettype none
interface ovl_if;
  logic [9:0] tc;
  logic [15:0] level;
  logic [15:0] current;
  logic alarm;
  modport ctl (output tc, output level, output current, input alarm);
  modport model (input tc, input level, input current, output alarm);
endinterface
`default_nettype wire

// *** rtl/thermal_overload.sv ***
// electronic thermal overload detector
`timescale 1ns/10ps
`default_nettype none
module thermal_overload #(
  parameter int TICK_CYC = pfr_pkg::TC_STEP_CYC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  ovl_if.model ovl
);
  typedef struct packed {
    logic [31:0] tick;
    logic [9:0] tenths;
    logic alarm;
  } th_state_t;
  th_state_t st_r, st_nxt;
  logic hot;

  always_comb begin
    // zero level means protection off
    hot = (ovl.level != 16'h0000) &&
      ({1'b0, ovl.current, 1'b0} >=
       ({2'b00, ovl.level} + {1'b0, ovl.level, 1'b0}));
    st_nxt = st_r;
    if (!hot) begin
      // no heat memory: cools at once below 150 percent
      st_nxt = '0;
    end else if (st_r.tenths >= ovl.tc) begin
      st_nxt.alarm = 1'b1;
    end else if (st_r.tick == 32'(TICK_CYC - 1)) begin
      st_nxt.tick = 32'h0000_0000;
      st_nxt.tenths = st_r.tenths + 10'h001;
    end else begin
      st_nxt.tick = st_r.tick + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ovl.alarm = st_r.alarm;

  chk_ovl_disabled: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in)
    ovl.level == 16'h0000 |=> !ovl.alarm)
    else $error("overload alarm while protection disabled");
  chk_ovl_raise: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in)
    hot && st_r.tenths >= ovl.tc && !st_r.alarm |=> ovl.alarm)
    else $error("overload alarm missing after time constant");
endmodule
`default_nettype wire

// *** rtl/restart_wait_timer.sv ***
// run-command wait timer for the restart sequence
`timescale 1ns/10ps
`default_nettype none
module restart_wait_timer #(
  parameter int WAIT_CYC = pfr_pkg::RUN_WAIT_CYC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic stop_in,
  output logic expire_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic expire;
  } tm_state_t;
  tm_state_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.expire = 1'b0;
    if (stop_in) begin
      st_nxt.busy = 1'b0;
      st_nxt.cnt = 32'h0000_0000;
    end else if (start_in) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = 32'h0000_0000;
    end else if (st_r.busy) begin
      if (st_r.cnt == 32'(WAIT_CYC - 1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.expire = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expire_out = st_r.expire;

  chk_wait_end: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in)
    st_r.busy && !stop_in && !start_in && st_r.cnt == 32'(WAIT_CYC - 1)
    |=> expire_out && !st_r.busy)
    else $error("wait timer did not expire on time");
endmodule
`default_nettype wire

// *** rtl/power_fail_restart_control.sv ***
// power-fail restart supervisor with thermal time-constant setting
//
// Behaviour
// - the time constant stays within 0.5 to 75.0 min in 0.1 min steps.
// - overload alarm once 150% of the level lasts the time constant.
// - default time constant is 5 min small and 10 min large motors.
// - mode 0: undervoltage shuts output, raises the alarm, coasts.
// - mode 1: output shuts silently, the alarm comes when power returns.
// - mode 3: below the continuous level, ride-through control starts.
// - mode 3: at undervoltage store frequency, shut output, coast.
// - mode 4: at undervoltage store frequency, shut output, coast.
// - modes 3 and 4 restart at the stored frequency on power and run.
// - mode 5 restarts at the starting frequency on power and run.
// - modes 3, 4 and 5 arm the restart on their own when power returns.
// - a zero overload level switches the thermal protection off.
// - after recovery a run command is awaited 2 s, else no restart.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module power_fail_restart_control #(
  parameter int RUN_WAIT_CYC = pfr_pkg::RUN_WAIT_CYC,
  parameter int TC_STEP_CYC = pfr_pkg::TC_STEP_CYC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic bus_below_uv_in,
  input wire logic bus_below_cont_in,
  input wire logic power_restored_in,
  input wire logic run_cmd_in,
  input wire logic large_capacity_in,
  input wire logic [15:0] out_freq_in,
  input wire logic [15:0] motor_current_in,
  output logic output_shutdown_out,
  output logic uv_alarm_out,
  output logic cont_run_out,
  output logic restart_req_out,
  output logic [15:0] restart_freq_out,
  output logic [15:0] saved_freq_out,
  output logic ovl_alarm_out,
  output logic irq_out
);
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [1:0] boot;
    logic loaded;
    logic [2:0] power_fail_restart_mode;
    logic [2:0] pf_mode;
    logic [9:0] thermal_time_constant_setting;
    logic [15:0] overload_detect_level_setting;
    logic [15:0] starting_frequency_setting;
    logic [4:0] status;
    logic [4:0] mask;
    logic [15:0] saved;
    pfr_pkg::pf_state_t state;
    logic shutdown;
    logic uv_alarm;
    logic cont_run;
    logic restart_req;
    logic [15:0] restart_freq;
    logic ovl_q;
    logic irq;
    logic wait_start;
    logic [15:0] rdata;
  } ctl_state_t;
  ctl_state_t st_r, st_nxt;

  logic uv_s, cont_s, pwr_s, run_s, strap_s;
  logic [2:0] mode_f;
  logic [4:0] ev;
  logic stat_clr;
  logic expired;
  logic run_like;

  function automatic logic [2:0] fold_mode(input logic [2:0] v);
    case (v)
      pfr_pkg::MODE_TRIP_LATE, pfr_pkg::MODE_RIDE,
      pfr_pkg::MODE_SAVED, pfr_pkg::MODE_START: fold_mode = v;
      default: fold_mode = pfr_pkg::MODE_TRIP;
    endcase
  endfunction

  assign uv_s = st_r.sync2[pfr_pkg::SYN_UV];
  assign cont_s = st_r.sync2[pfr_pkg::SYN_CONT];
  assign pwr_s = st_r.sync2[pfr_pkg::SYN_PWR];
  assign run_s = st_r.sync2[pfr_pkg::SYN_RUN];
  assign strap_s = st_r.sync2[pfr_pkg::SYN_STRAP];
  assign mode_f = fold_mode(st_r.power_fail_restart_mode);
  assign run_like = (st_r.state == pfr_pkg::ST_RUN) ||
    (st_r.state == pfr_pkg::ST_CONT);

  ovl_if ovl_bus ();
  assign ovl_bus.tc = st_r.thermal_time_constant_setting;
  assign ovl_bus.level = st_r.overload_detect_level_setting;
  assign ovl_bus.current = motor_current_in;

  thermal_overload #(.TICK_CYC(TC_STEP_CYC)) u_thermal (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ovl(ovl_bus.model)
  );

  restart_wait_timer #(.WAIT_CYC(RUN_WAIT_CYC)) u_wait (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(st_r.wait_start),
    .stop_in(st_r.state != pfr_pkg::ST_WAIT),
    .expire_out(expired)
  );

  always_comb begin
    st_nxt = st_r;
    ev = 5'h00;
    stat_clr = 1'b0;
    st_nxt.sync1 = {large_capacity_in, run_cmd_in, power_restored_in,
      bus_below_cont_in, bus_below_uv_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.restart_req = 1'b0;
    st_nxt.wait_start = 1'b0;
    st_nxt.rdata = 16'h0000;
    st_nxt.ovl_q = ovl_bus.alarm;
    ev[pfr_pkg::EV_OVL] = ovl_bus.alarm && !st_r.ovl_q;
    // strap sampled once the synchroniser has settled
    if (!st_r.loaded) begin
      st_nxt.boot = st_r.boot + 2'h1;
      if (st_r.boot == 2'h3) begin
        st_nxt.loaded = 1'b1;
        st_nxt.thermal_time_constant_setting = strap_s ?
          pfr_pkg::TC_DEF_LARGE : pfr_pkg::TC_DEF_SMALL;
      end
    end
    case (st_r.state)
      pfr_pkg::ST_RUN, pfr_pkg::ST_CONT: begin
        if (uv_s) begin
          ev[pfr_pkg::EV_PF] = 1'b1;
          st_nxt.shutdown = 1'b1;
          st_nxt.cont_run = 1'b0;
          st_nxt.pf_mode = mode_f;
          st_nxt.state = pfr_pkg::ST_COAST;
          case (mode_f)
            pfr_pkg::MODE_TRIP_LATE: begin
              st_nxt.uv_alarm = 1'b0;
            end
            pfr_pkg::MODE_RIDE, pfr_pkg::MODE_SAVED: begin
              st_nxt.saved = out_freq_in;
            end
            pfr_pkg::MODE_START: begin
              st_nxt.saved = st_r.saved;
            end
            default: begin
              st_nxt.uv_alarm = 1'b1;
              ev[pfr_pkg::EV_UV] = 1'b1;
              st_nxt.state = pfr_pkg::ST_TRIP;
            end
          endcase
        end else if (mode_f == pfr_pkg::MODE_RIDE && cont_s) begin
          st_nxt.cont_run = 1'b1;
          st_nxt.state = pfr_pkg::ST_CONT;
        end else begin
          st_nxt.cont_run = 1'b0;
          st_nxt.state = pfr_pkg::ST_RUN;
        end
      end
      pfr_pkg::ST_COAST: begin
        if (pwr_s && !uv_s) begin
          if (st_r.pf_mode == pfr_pkg::MODE_TRIP_LATE) begin
            st_nxt.uv_alarm = 1'b1;
            ev[pfr_pkg::EV_UV] = 1'b1;
            st_nxt.state = pfr_pkg::ST_TRIP;
          end else begin
            st_nxt.state = pfr_pkg::ST_WAIT;
            st_nxt.wait_start = 1'b1;
          end
        end
      end
      pfr_pkg::ST_WAIT: begin
        if (uv_s) begin
          st_nxt.state = pfr_pkg::ST_COAST;
        end else if (run_s) begin
          st_nxt.restart_req = 1'b1;
          st_nxt.shutdown = 1'b0;
          ev[pfr_pkg::EV_RESTART] = 1'b1;
          st_nxt.state = pfr_pkg::ST_RUN;
          if (st_r.pf_mode == pfr_pkg::MODE_START) begin
            st_nxt.restart_freq = st_r.starting_frequency_setting;
          end else begin
            st_nxt.restart_freq = st_r.saved;
          end
        end else if (expired) begin
          ev[pfr_pkg::EV_CANCEL] = 1'b1;
          st_nxt.state = pfr_pkg::ST_TRIP;
        end
      end
      pfr_pkg::ST_TRIP: begin
        st_nxt.shutdown = 1'b1;
      end
      default: begin
        st_nxt.shutdown = 1'b1;
        st_nxt.state = pfr_pkg::ST_TRIP;
      end
    endcase
    if (reg_wr_in) begin
      case (reg_addr_in)
        pfr_pkg::REG_CTRL: begin
          st_nxt.power_fail_restart_mode = reg_wdata_in[2:0];
          if (reg_wdata_in[pfr_pkg::CTRL_CLR_BIT] &&
              st_r.state == pfr_pkg::ST_TRIP) begin
            st_nxt.state = pfr_pkg::ST_RUN;
            st_nxt.shutdown = 1'b0;
            st_nxt.uv_alarm = 1'b0;
          end
        end
        pfr_pkg::REG_TC: begin
          // out-of-range settings clamp rather than reject
          if (reg_wdata_in < pfr_pkg::TC_MIN) begin
            st_nxt.thermal_time_constant_setting =
              pfr_pkg::TC_MIN[9:0];
          end else if (reg_wdata_in > pfr_pkg::TC_MAX) begin
            st_nxt.thermal_time_constant_setting =
              pfr_pkg::TC_MAX[9:0];
          end else begin
            st_nxt.thermal_time_constant_setting = reg_wdata_in[9:0];
          end
        end
        pfr_pkg::REG_LEVEL: begin
          st_nxt.overload_detect_level_setting = reg_wdata_in;
        end
        pfr_pkg::REG_START: begin
          st_nxt.starting_frequency_setting = reg_wdata_in;
        end
        pfr_pkg::REG_MASK: begin
          st_nxt.mask = reg_wdata_in[4:0];
        end
        default: begin
          st_nxt.mask = st_r.mask;
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        pfr_pkg::REG_CTRL: st_nxt.rdata = {13'h0000,
          st_r.power_fail_restart_mode};
        pfr_pkg::REG_TC: st_nxt.rdata = {6'h00,
          st_r.thermal_time_constant_setting};
        pfr_pkg::REG_LEVEL: st_nxt.rdata = st_r.overload_detect_level_setting;
        pfr_pkg::REG_START: st_nxt.rdata = st_r.starting_frequency_setting;
        pfr_pkg::REG_STATUS: begin
          st_nxt.rdata = {11'h000, st_r.status};
          stat_clr = 1'b1;
        end
        pfr_pkg::REG_MASK: st_nxt.rdata = {11'h000, st_r.mask};
        pfr_pkg::REG_SAVED: st_nxt.rdata = st_r.saved;
        pfr_pkg::REG_STATE: st_nxt.rdata = {11'h000, st_r.state};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // a new event beats the clearing read
    st_nxt.status = (stat_clr ? 5'h00 : st_r.status) | ev;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
      st_r.state <= pfr_pkg::ST_RUN;
      st_r.power_fail_restart_mode <= pfr_pkg::MODE_RST;
      st_r.thermal_time_constant_setting <= pfr_pkg::TC_DEF_SMALL;
      st_r.overload_detect_level_setting <= pfr_pkg::LEVEL_RST;
      st_r.starting_frequency_setting <= pfr_pkg::START_FREQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign output_shutdown_out = st_r.shutdown;
  assign uv_alarm_out = st_r.uv_alarm;
  assign cont_run_out = st_r.cont_run;
  assign restart_req_out = st_r.restart_req;
  assign restart_freq_out = st_r.restart_freq;
  assign saved_freq_out = st_r.saved;
  assign ovl_alarm_out = st_r.ovl_q;
  assign irq_out = st_r.irq;

  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_fail(logic [2:0] md);
    run_like && uv_s && mode_f == md;
  endsequence
  sequence s_go;
    st_r.state == pfr_pkg::ST_WAIT && run_s && !uv_s;
  endsequence

  chk_trip_now: assert property (
    s_fail(pfr_pkg::MODE_TRIP) |=> st_r.shutdown && st_r.uv_alarm)
    else $error("mode 0 did not trip at once");
  chk_bad_mode: assert property (
    run_like && uv_s && !(st_r.power_fail_restart_mode inside
    {3'h1, 3'h3, 3'h4, 3'h5}) |=> st_r.state == pfr_pkg::ST_TRIP)
    else $error("undefined mode did not trip");
  chk_late_alarm: assert property (
    s_fail(pfr_pkg::MODE_TRIP_LATE) |=> st_r.shutdown && !st_r.uv_alarm)
    else $error("mode 1 raised alarm too early");
  chk_cont_ride: assert property (
    run_like && !uv_s && cont_s && mode_f == pfr_pkg::MODE_RIDE
    |=> cont_run_out && st_r.state == pfr_pkg::ST_CONT)
    else $error("continuous running not started");
  chk_freq_saved: assert property (
    s_fail(pfr_pkg::MODE_RIDE) or s_fail(pfr_pkg::MODE_SAVED)
    |=> saved_freq_out == $past(out_freq_in) && st_r.shutdown)
    else $error("frequency not stored on failure");
  chk_restart_saved: assert property (
    s_go ##0 st_r.pf_mode != pfr_pkg::MODE_START
    |=> restart_req_out && restart_freq_out == $past(st_r.saved))
    else $error("restart not at stored frequency");
  chk_restart_start: assert property (
    s_go ##0 st_r.pf_mode == pfr_pkg::MODE_START
    |=> restart_freq_out == $past(st_r.starting_frequency_setting))
    else $error("restart not at starting frequency");
  chk_auto_wait: assert property (
    st_r.state == pfr_pkg::ST_COAST && pwr_s && !uv_s &&
    st_r.pf_mode != pfr_pkg::MODE_TRIP_LATE
    |=> st_r.state == pfr_pkg::ST_WAIT && st_r.wait_start)
    else $error("recovery did not arm the restart");
  chk_wait_cancel: assert property (
    st_r.state == pfr_pkg::ST_WAIT && expired && !run_s && !uv_s
    |=> st_r.state == pfr_pkg::ST_TRIP && st_r.status[pfr_pkg::EV_CANCEL])
    else $error("restart not cancelled after wait");
  chk_tc_range: assert property (
    st_r.loaded |-> {6'h00, st_r.thermal_time_constant_setting} >=
    pfr_pkg::TC_MIN && {6'h00, st_r.thermal_time_constant_setting} <=
    pfr_pkg::TC_MAX)
    else $error("time constant out of range");
  chk_tc_default: assert property (
    !st_r.loaded && st_r.boot == 2'h3 |=> st_r.thermal_time_constant_setting
    == ($past(strap_s) ? pfr_pkg::TC_DEF_LARGE : pfr_pkg::TC_DEF_SMALL))
    else $error("wrong default time constant");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the power-fail restart supervisor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic uv = 1'b0;
  logic cont = 1'b0;
  logic pwr = 1'b0;
  logic run = 1'b0;
  logic strap = 1'b0;
  logic [15:0] freq = 16'h0000;
  logic [15:0] cur = 16'h0000;
  logic shut, uv_alarm, cont_run, rs_req, ovl, irq;
  logic [15:0] rs_freq, saved;
  logic [15:0] got;
  logic [15:0] rf;
  logic seen;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  int n;
  logic [2:0] trip_modes [3] = '{3'h0, 3'h2, 3'h7};

  // short counts keep the run brief: 20-cycle wait, 4 cycles per 0.1 min
  power_fail_restart_control #(.RUN_WAIT_CYC(20), .TC_STEP_CYC(4))
      power_fail_restart_control_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .bus_below_uv_in(uv),
    .bus_below_cont_in(cont), .power_restored_in(pwr),
    .run_cmd_in(run), .large_capacity_in(strap), .out_freq_in(freq),
    .motor_current_in(cur), .output_shutdown_out(shut),
    .uv_alarm_out(uv_alarm), .cont_run_out(cont_run),
    .restart_req_out(rs_req), .restart_freq_out(rs_freq),
    .saved_freq_out(saved), .ovl_alarm_out(ovl), .irq_out(irq)
  );

  always #10 mclk_in = ~mclk_in;

  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] act);
    samples_checked++;
    if (act !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, act);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task automatic do_reset(input logic s);
    @(posedge mclk_in);
    strap <= s;
    sys_rst_in <= 1'b1;
    cyc(16);
    @(posedge mclk_in) sys_rst_in <= 1'b0;
    cyc(8);
  endtask

  // pin changes need sync plus one edge; 6 cycles leave margin
  task automatic fail_uv();
    @(posedge mclk_in) uv <= 1'b1;
    cyc(6);
  endtask

  task automatic clear_trip(input logic [2:0] m);
    @(posedge mclk_in) pwr <= 1'b0;
    uv <= 1'b0;
    cont <= 1'b0;
    cyc(6);
    wr_reg(pfr_pkg::REG_CTRL, {11'h000, 1'b1, 1'b0, m});
    rd_reg(pfr_pkg::REG_STATUS, got);
    cyc(3);
  endtask

  // restore power and watch for the one-cycle restart pulse
  task automatic recover();
    @(posedge mclk_in);
    uv <= 1'b0;
    cont <= 1'b0;
    pwr <= 1'b1;
    seen = 1'b0;
    rf = 16'h0000;
    repeat (60) begin
      @(posedge mclk_in);
      #1;
      if (rs_req === 1'b1 && seen === 1'b0) begin
        seen = 1'b1;
        rf = rs_freq;
      end
    end
  endtask

  initial begin
    do_reset(1'b1);
    rd_reg(pfr_pkg::REG_TC, got);
    chk("tc large", 16'h0064, got);
    do_reset(1'b0);
    rd_reg(pfr_pkg::REG_TC, got);
    chk("tc small", 16'h0032, got);
    rd_reg(pfr_pkg::REG_LEVEL, got);
    chk("level", 16'h0064, got);
    rd_reg(pfr_pkg::REG_START, got);
    chk("start", 16'h0005, got);
    rd_reg(pfr_pkg::REG_STATE, got);
    chk("state", 16'h0001, got);
    rd_reg(4'hF, got);
    chk("unmapped", 16'h0000, got);
    wr_reg(pfr_pkg::REG_TC, 16'h0000);
    rd_reg(pfr_pkg::REG_TC, got);
    chk("tc low", 16'h0005, got);
    wr_reg(pfr_pkg::REG_TC, 16'hFFFF);
    rd_reg(pfr_pkg::REG_TC, got);
    chk("tc high", 16'h02EE, got);
    wr_reg(pfr_pkg::REG_TC, 16'h0123);
    rd_reg(pfr_pkg::REG_TC, got);
    chk("tc mid", 16'h0123, got);
    wr_reg(pfr_pkg::REG_MASK, 16'h0001);
    // immediate trip, for mode 0 and undefined codes alike
    foreach (trip_modes[i]) begin
      wr_reg(pfr_pkg::REG_CTRL, {13'h0000, trip_modes[i]});
      fail_uv();
      chk("shutdown", 16'h0001, {15'h0000, shut});
      chk("uv alarm", 16'h0001, {15'h0000, uv_alarm});
      chk("irq set", 16'h0001, {15'h0000, irq});
      rd_reg(pfr_pkg::REG_STATE, got);
      chk("trip state", 16'h0010, got);
      rd_reg(pfr_pkg::REG_STATUS, got);
      chk("uv event", 16'h0001, got & 16'h0001);
      clear_trip(trip_modes[i]);
      chk("irq clear", 16'h0000, {15'h0000, irq});
      chk("shut clear", 16'h0000, {15'h0000, shut});
    end
    // trip only after power comes back
    wr_reg(pfr_pkg::REG_CTRL, 16'h0001);
    fail_uv();
    chk("m1 shutdown", 16'h0001, {15'h0000, shut});
    chk("m1 no alarm", 16'h0000, {15'h0000, uv_alarm});
    @(posedge mclk_in) uv <= 1'b0;
    pwr <= 1'b1;
    cyc(8);
    chk("m1 alarm", 16'h0001, {15'h0000, uv_alarm});
    chk("m1 coast", 16'h0001, {15'h0000, shut});
    clear_trip(3'h1);
    // ride through, then fail and restart at the stored frequency
    wr_reg(pfr_pkg::REG_CTRL, 16'h0003);
    @(posedge mclk_in) freq <= 16'h0321;
    cont <= 1'b1;
    cyc(6);
    chk("cont on", 16'h0001, {15'h0000, cont_run});
    chk("cont no shut", 16'h0000, {15'h0000, shut});
    @(posedge mclk_in) cont <= 1'b0;
    cyc(6);
    chk("cont off", 16'h0000, {15'h0000, cont_run});
    @(posedge mclk_in) cont <= 1'b1;
    cyc(6);
    fail_uv();
    chk("m3 shutdown", 16'h0001, {15'h0000, shut});
    chk("m3 saved", 16'h0321, saved);
    @(posedge mclk_in) freq <= 16'h0999;
    run <= 1'b1;
    recover();
    chk("m3 restart", 16'h0001, {15'h0000, seen});
    chk("m3 freq", 16'h0321, rf);
    chk("m3 running", 16'h0000, {15'h0000, shut});
    rd_reg(pfr_pkg::REG_STATUS, got);
    chk("restart event", 16'h0004, got & 16'h0004);
    @(posedge mclk_in) pwr <= 1'b0;
    // store at undervoltage, restart at that frequency
    wr_reg(pfr_pkg::REG_CTRL, 16'h0004);
    @(posedge mclk_in) freq <= 16'h0456;
    cyc(2);
    fail_uv();
    chk("m4 shutdown", 16'h0001, {15'h0000, shut});
    chk("m4 saved", 16'h0456, saved);
    @(posedge mclk_in) freq <= 16'h0111;
    recover();
    chk("m4 restart", 16'h0001, {15'h0000, seen});
    chk("m4 freq", 16'h0456, rf);
    @(posedge mclk_in) pwr <= 1'b0;
    // restart from the starting frequency
    wr_reg(pfr_pkg::REG_START, 16'h0077);
    wr_reg(pfr_pkg::REG_CTRL, 16'h0005);
    fail_uv();
    recover();
    chk("m5 restart", 16'h0001, {15'h0000, seen});
    chk("m5 freq", 16'h0077, rf);
    @(posedge mclk_in) pwr <= 1'b0;
    // a late run command inside the wait still restarts
    run <= 1'b0;
    wr_reg(pfr_pkg::REG_CTRL, 16'h0004);
    fail_uv();
    @(posedge mclk_in) uv <= 1'b0;
    pwr <= 1'b1;
    cyc(14);
    @(posedge mclk_in) run <= 1'b1;
    cyc(8);
    chk("late run", 16'h0000, {15'h0000, shut});
    // no run command inside the wait: restart dropped
    @(posedge mclk_in) pwr <= 1'b0;
    run <= 1'b0;
    fail_uv();
    rd_reg(pfr_pkg::REG_STATUS, got);
    recover();
    chk("no restart", 16'h0000, {15'h0000, seen});
    chk("stay shut", 16'h0001, {15'h0000, shut});
    rd_reg(pfr_pkg::REG_STATE, got);
    chk("cancel state", 16'h0010, got);
    rd_reg(pfr_pkg::REG_STATUS, got);
    chk("cancel event", 16'h0008, got & 16'h0008);
    clear_trip(3'h4);
    // overload at exactly 150% of the level, tc 0.5 min = 20 cycles
    wr_reg(pfr_pkg::REG_TC, 16'h0005);
    wr_reg(pfr_pkg::REG_LEVEL, 16'h0010);
    @(posedge mclk_in) cur <= 16'h0018;
    n = 0;
    while (ovl !== 1'b1 && n < 80) begin
      cyc(1);
      n++;
    end
    chk("ovl early", 16'h0001, {15'h0000, n >= 19});
    chk("ovl late", 16'h0001, {15'h0000, n <= 26});
    @(posedge mclk_in) cur <= 16'h0017;
    cyc(4);
    chk("ovl fall", 16'h0000, {15'h0000, ovl});
    wr_reg(pfr_pkg::REG_LEVEL, 16'h0000);
    @(posedge mclk_in) cur <= 16'hFFFF;
    cyc(80);
    chk("ovl off", 16'h0000, {15'h0000, ovl});
    end_sim();
  end
endmodule
`default_nettype wire
